// [src/pvg_defs.vh]
// constants for the input-threshold, phase-position and current-gain command block
`ifndef PVG_DEFS_VH
`define PVG_DEFS_VH
// command codes
`define PVG_CMD_VIN_ON 8'h35
`define PVG_CMD_INPUT_TURN_OFF_THRESHOLD 8'h36
`define PVG_CMD_PHASE 8'h37
`define PVG_CMD_GAIN 8'h38
// linear word fields
`define PVG_EXP_HI 15
`define PVG_EXP_LO 11
`define PVG_MAN_HI 10
`define PVG_MAN_LO 0
// phase word fields
`define PVG_GRP_HI 11
`define PVG_GRP_LO 8
`define PVG_CNT_HI 7
`define PVG_CNT_LO 4
`define PVG_POS_HI 3
`define PVG_POS_LO 0
// reset values
`define PVG_THR_EXP_RST 5'h1E
`define PVG_ON_MAN_RST 11'h028
`define PVG_OFF_MAN_RST 11'h024
`define PVG_GAIN_EXP_RST 5'h19
`define PVG_GAIN_MAN_RST 11'h080
`define PVG_PHASE_RST 16'h0010
// threshold hardware levels in quarter volts
`define PVG_ON_MIN_QV 16'h000A
`define PVG_OFF_MIN_QV 16'h0009
`define PVG_THR_MAX_QV 16'h003F
// scale biases: quarter volts, sixty-fourths, 1/2048 units
`define PVG_QV_BIAS 6'h02
`define PVG_G64_BIAS 6'h06
`define PVG_G2K_BIAS 6'h0B
`define PVG_GAIN64_MAX 16'h007F
`define PVG_G2K_FRAC 11
// phase step per position, degrees
`define PVG_DEG_STEP1 9'h000
`define PVG_DEG_STEP2 9'h0B4
`define PVG_DEG_STEP3 9'h078
`define PVG_DEG_STEP4 9'h05A
`endif

// [src/pvg_cmd_regs.v]
// threshold, phase-position and current-gain command registers of the converter's pmbus side
// How it works
// RULE1 - turn-on threshold held, linear, fixed exponent
// RULE2 - thresholds round down, applied and restored
// RULE3 - turn-on levels 2.50 to 15.75 V
// RULE4 - undervoltage fault masked until first turn-on
// RULE5 - only power-on reset rearms that masking
// RULE6 - turn-off threshold at code 36h, word access
// RULE7 - enabled but below turn-off sets status
// RULE8 - turn-off word: exponent reset, nvm mantissa
// RULE9 - turn-off levels 2.25 to 15.75 V
// RULE10 - out-of-range writes flagged as invalid data
// RULE11 - host keeps turn-off below turn-on
// RULE12 - phase word top nibble reads zero
// RULE13 - group, count 1-4, position below count
// RULE14 - delay is 360 over count times position
// RULE15 - phase word writable only single-phase
// RULE16 - writability latched once after power-on
// RULE17 - gain at 38h scales reported current, default 1
// RULE18 - gain word: exponent reset 11001b, nvm mantissa
// RULE19 - gain change rescales overcurrent limits
// RULE20 - running gain kept at full resolution (a store rounds the running gain itself to 1/64)
// RULE21 - store, restore, power cycle round to 1/64
// RULE22 - one threshold mantissa step is quarter volt
`timescale 1ns/1ps
`include "pvg_defs.vh"
module pvg_cmd_regs (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // command port from the pmbus engine
    input wire [7:0] cmd_code,
    input wire cmd_wr,
    input wire [15:0] cmd_wr_data,
    input wire cmd_rd,
    output reg [15:0] cmd_rd_data,
    output reg cmd_rd_valid,
    output reg invalid_data,
    output reg write_denied,
    // nvm transfer
    input wire nvm_restore,
    input wire nvm_store,
    input wire [15:0] nvm_vin_on,
    input wire [15:0] nvm_input_turn_off_threshold,
    input wire [15:0] nvm_phase,
    input wire [15:0] nvm_gain,
    // stack strap and analogue side
    input wire stack_multi,
    input wire [7:0] power_input_voltage,
    input wire conv_enable_ok,
    input wire clear_status,
    input wire [15:0] iout_sensed,
    input wire [15:0] oc_fault_limit_raw,
    input wire [15:0] oc_warn_limit_raw,
    // hardware settings and status
    output reg [5:0] turn_on_level,
    output reg [5:0] turn_off_level,
    output reg [8:0] phase_delay_deg,
    output reg [15:0] iout_reported,
    output reg [15:0] oc_fault_limit_eff,
    output reg [15:0] oc_warn_limit_eff,
    output reg input_undervoltage_fault,
    output reg uv_mask_released,
    output reg off_low_input,
    output reg phase_write_locked
);

    // linear value times 2^(exp+bias), saturated; rnd adds half an lsb before a right shift
    // a negative mantissa gives zero, which the threshold lower limits reject but the gain cap and the nvm rounding let through;
    // shifts that would leave the 16-bit result saturate rather than wrap,
    // and right shifts past the word give zero instead of a stale remainder
    function [15:0] lin_scale;
        input [4:0] e;
        input [10:0] m;
        input [5:0] bias;
        input rnd;
        reg signed [7:0] sh;
        reg [31:0] acc;
        begin
            sh = {{3{e[4]}}, e} + {2'b00, bias};
            acc = 32'h0;
            if (m[10]) begin
                acc = 32'h0;
            end else if (sh >= 8'sd16) begin
                acc = 32'h0000FFFF;
            end else if (sh >= 8'sd0) begin
                acc = {21'h0, m} << sh[3:0];
            end else begin
                acc = {21'h0, m};
                if (rnd && (sh >= -8'sd16)) begin
                    acc = acc + (32'h1 << (-sh - 8'sd1));
                end
                acc = (sh < -8'sd16) ? 32'h0 : (acc >> (-sh));
            end
            lin_scale = (acc > 32'h0000FFFF) ? 16'hFFFF : acc[15:0];
        end
    endfunction

    // product shifted back to 1x and saturated
    // the product is formed at 32 bits so a full-scale input times a gain
    // near two cannot overflow before the shift brings it back down
    function [15:0] gain_mul;
        input [15:0] a;
        input [15:0] g;
        reg [31:0] p;
        begin
            p = (a * g) >> `PVG_G2K_FRAC;
            gain_mul = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
        end
    endfunction

    // gain rounded to sixty-fourths, capped, stored with the reset exponent
    // halves round up; the cap keeps the word inside what the nvm can hold,
    // and the mantissa is doubled because the reset exponent counts 1/128
    function [15:0] gain_round;
        input [15:0] w;
        reg [15:0] g64;
        begin
            g64 = lin_scale(w[`PVG_EXP_HI:`PVG_EXP_LO], w[`PVG_MAN_HI:`PVG_MAN_LO], `PVG_G64_BIAS, 1'b1);
            if (g64 > `PVG_GAIN64_MAX) begin
                g64 = `PVG_GAIN64_MAX; // RULE21
            end
            gain_round = {`PVG_GAIN_EXP_RST, g64[9:0], 1'b0}; // RULE21
        end
    endfunction

    // threshold rounded down to whole quarter volts, stored with the fixed exponent
    // the floor comes from the truncating right shift; values under the lower
    // limit are kept as they are and only the top end saturates
    function [15:0] thr_round;
        input [15:0] w;
        reg [15:0] q;
        begin
            q = lin_scale(w[`PVG_EXP_HI:`PVG_EXP_LO], w[`PVG_MAN_HI:`PVG_MAN_LO], `PVG_QV_BIAS, 1'b0);
            if (q > `PVG_THR_MAX_QV) begin
                q = `PVG_THR_MAX_QV;
            end
            thr_round = {`PVG_THR_EXP_RST, q[10:0]}; // RULE2
        end
    endfunction

    reg [15:0] vin_on_ff;
    reg [15:0] input_turn_off_threshold_ff;
    reg [15:0] phase_ff;
    reg [15:0] gain_ff;
    reg strap_taken_ff;
    reg [15:0] nxt_vin_on;
    reg [15:0] nxt_input_turn_off_threshold;
    reg [15:0] nxt_phase;
    reg [15:0] nxt_gain;
    reg nxt_invalid;
    reg nxt_denied;

    // decoded values of the incoming write word
    // the checks floor first, so a finer value inside the range is accepted
    // and only the hardware level is coarser than what the host wrote
    wire [4:0] wr_exp = cmd_wr_data[`PVG_EXP_HI:`PVG_EXP_LO];
    wire [10:0] wr_man = cmd_wr_data[`PVG_MAN_HI:`PVG_MAN_LO];
    wire [15:0] wr_qv = lin_scale(wr_exp, wr_man, `PVG_QV_BIAS, 1'b0); // RULE22
    wire [15:0] wr_g64 = lin_scale(wr_exp, wr_man, `PVG_G64_BIAS, 1'b0);
    wire [3:0] wr_cnt = cmd_wr_data[`PVG_CNT_HI:`PVG_CNT_LO];
    wire [3:0] wr_pos = cmd_wr_data[`PVG_POS_HI:`PVG_POS_LO];
    wire on_ok = !wr_man[10] && (wr_qv >= `PVG_ON_MIN_QV) && (wr_qv <= `PVG_THR_MAX_QV); // RULE3
    wire off_ok = !wr_man[10] && (wr_qv >= `PVG_OFF_MIN_QV) && (wr_qv <= `PVG_THR_MAX_QV); // RULE9
    wire phase_ok = (wr_cnt >= 4'h1) && (wr_cnt <= 4'h4) && (wr_pos < wr_cnt); // RULE13
    wire gain_ok = !wr_man[10] && (wr_man != 11'h000) && (wr_g64 <= `PVG_GAIN64_MAX);

    // current hardware levels and gain in 1/2048 units
    // the stored words read back exactly as written, while the levels and the
    // gain multiplier below are always derived from them afresh
    wire [15:0] on_qv = lin_scale(vin_on_ff[`PVG_EXP_HI:`PVG_EXP_LO], vin_on_ff[`PVG_MAN_HI:`PVG_MAN_LO],
                                  `PVG_QV_BIAS, 1'b0);
    wire [15:0] off_qv = lin_scale(input_turn_off_threshold_ff[`PVG_EXP_HI:`PVG_EXP_LO], input_turn_off_threshold_ff[`PVG_MAN_HI:`PVG_MAN_LO],
                                   `PVG_QV_BIAS, 1'b0);
    wire [15:0] gain_2k = lin_scale(gain_ff[`PVG_EXP_HI:`PVG_EXP_LO], gain_ff[`PVG_MAN_HI:`PVG_MAN_LO],
                                    `PVG_G2K_BIAS, 1'b0); // RULE20
    wire below_off = {8'h00, power_input_voltage} < off_qv;
    wire above_on = {8'h00, power_input_voltage} > on_qv;

    // next register contents from writes and nvm transfers
    // restore wins over store and store over a host write; a write that lands
    // in the same cycle as either is dropped without a flag, so the nvm
    // engine must keep the command port quiet while it runs
    always @* begin
        nxt_vin_on = vin_on_ff;
        nxt_input_turn_off_threshold = input_turn_off_threshold_ff;
        nxt_phase = phase_ff;
        nxt_gain = gain_ff;
        nxt_invalid = 1'b0;
        nxt_denied = 1'b0;
        if (nvm_restore) begin
            nxt_vin_on = thr_round(nvm_vin_on); // RULE2
            nxt_input_turn_off_threshold = thr_round(nvm_input_turn_off_threshold); // RULE2
            nxt_phase = {4'h0, nvm_phase[11:0]};
            nxt_gain = gain_round(nvm_gain); // RULE21
        end else if (nvm_store) begin
            nxt_gain = gain_round(gain_ff); // RULE21
        end else if (cmd_wr) begin
            case (cmd_code)
                `PVG_CMD_VIN_ON: begin
                    if (on_ok) begin
                        nxt_vin_on = cmd_wr_data; // RULE1
                    end else begin
                        nxt_invalid = 1'b1; // RULE10
                    end
                end
                `PVG_CMD_INPUT_TURN_OFF_THRESHOLD: begin
                    if (off_ok) begin
                        nxt_input_turn_off_threshold = cmd_wr_data; // RULE6
                    end else begin
                        nxt_invalid = 1'b1; // RULE10
                    end
                end
                `PVG_CMD_PHASE: begin
                    if (phase_write_locked) begin
                        nxt_denied = 1'b1; // RULE15
                    end else if (phase_ok) begin
                        nxt_phase = {4'h0, cmd_wr_data[11:0]}; // RULE12
                    end else begin
                        nxt_invalid = 1'b1; // RULE10
                    end
                end
                `PVG_CMD_GAIN: begin
                    if (gain_ok) begin
                        nxt_gain = cmd_wr_data; // RULE20
                    end else begin
                        nxt_invalid = 1'b1; // RULE10
                    end
                end
                default: begin
                    nxt_invalid = 1'b0;
                end
            endcase
        end
    end

    // register storage, reset to power-on values
    // the reset mantissas stand in for nvm contents until the first restore
    always @(posedge sys_clk) begin
        if (srst) begin
            vin_on_ff <= {`PVG_THR_EXP_RST, `PVG_ON_MAN_RST}; // RULE1
            input_turn_off_threshold_ff <= {`PVG_THR_EXP_RST, `PVG_OFF_MAN_RST}; // RULE8
            phase_ff <= `PVG_PHASE_RST;
            gain_ff <= {`PVG_GAIN_EXP_RST, `PVG_GAIN_MAN_RST}; // RULE18
            invalid_data <= 1'b0;
            write_denied <= 1'b0;
        end else begin
            vin_on_ff <= nxt_vin_on;
            input_turn_off_threshold_ff <= nxt_input_turn_off_threshold;
            phase_ff <= nxt_phase;
            gain_ff <= nxt_gain;
            invalid_data <= nxt_invalid;
            write_denied <= nxt_denied;
        end
    end

    // stack strap caught once on the first edge after reset release
    // later changes of the strap are ignored until the next reset, so a stack
    // can never be misaligned by a stray write to the phase word after that first edge
    always @(posedge sys_clk) begin
        if (srst) begin
            strap_taken_ff <= 1'b0;
            phase_write_locked <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            phase_write_locked <= stack_multi; // RULE16
        end
    end

    // read answer one cycle after the strobe
    // the data holds until the next read, so a slow host may sample it late
    always @(posedge sys_clk) begin
        if (srst) begin
            cmd_rd_data <= 16'h0000;
            cmd_rd_valid <= 1'b0;
        end else begin
            cmd_rd_valid <= cmd_rd;
            if (cmd_rd) begin
                case (cmd_code)
                    `PVG_CMD_VIN_ON: cmd_rd_data <= vin_on_ff;
                    `PVG_CMD_INPUT_TURN_OFF_THRESHOLD: cmd_rd_data <= input_turn_off_threshold_ff;
                    `PVG_CMD_PHASE: cmd_rd_data <= {4'h0, phase_ff[11:0]}; // RULE12
                    `PVG_CMD_GAIN: cmd_rd_data <= gain_ff;
                    default: cmd_rd_data <= 16'h0000;
                endcase
            end
        end
    end

    // undervoltage masking, released once, rearmed only by reset
    // enable toggles and nvm transfers do not touch the mask; the fault uses
    // the registered mask, so it can first assert one cycle after release
    always @(posedge sys_clk) begin
        if (srst) begin
            uv_mask_released <= 1'b0;
            input_undervoltage_fault <= 1'b0;
        end else begin
            if (above_on) begin
                uv_mask_released <= 1'b1; // RULE4 RULE5
            end
            input_undervoltage_fault <= uv_mask_released && below_off; // RULE4
        end
    end

    // sticky low-input shutdown status; a new event wins over the clear
    // the event is tested first so a clear in the same cycle cannot hide it
    always @(posedge sys_clk) begin
        if (srst) begin
            off_low_input <= 1'b0;
        end else if (conv_enable_ok && below_off) begin
            off_low_input <= 1'b1; // RULE7
        end else if (clear_status) begin
            off_low_input <= 1'b0;
        end
    end

    // hardware threshold levels, phase delay and gain-scaled outputs
    // these trail the stored words by one cycle, so the host sees a new level
    // two cycles after its write; unsupported counts give no delay
    always @(posedge sys_clk) begin
        if (srst) begin
            turn_on_level <= 6'h00;
            turn_off_level <= 6'h00;
            phase_delay_deg <= 9'h000;
            iout_reported <= 16'h0000;
            oc_fault_limit_eff <= 16'h0000;
            oc_warn_limit_eff <= 16'h0000;
        end else begin
            turn_on_level <= on_qv[5:0]; // RULE2 RULE3
            turn_off_level <= off_qv[5:0]; // RULE2 RULE9
            case (phase_ff[`PVG_CNT_HI:`PVG_CNT_LO])
                4'h2: phase_delay_deg <= `PVG_DEG_STEP2 * {5'h00, phase_ff[3:0]}; // RULE14
                4'h3: phase_delay_deg <= `PVG_DEG_STEP3 * {5'h00, phase_ff[3:0]}; // RULE14
                4'h4: phase_delay_deg <= `PVG_DEG_STEP4 * {5'h00, phase_ff[3:0]}; // RULE14
                default: phase_delay_deg <= `PVG_DEG_STEP1;
            endcase
            iout_reported <= gain_mul(iout_sensed, gain_2k); // RULE17
            oc_fault_limit_eff <= gain_mul(oc_fault_limit_raw, gain_2k); // RULE19
            oc_warn_limit_eff <= gain_mul(oc_warn_limit_raw, gain_2k); // RULE19
        end
    end

endmodule // pvg_cmd_regs

// [tb/pvg_host.sv]
// host model that issues word reads and writes on the command port
`timescale 1ns/1ps
module pvg_host (
    // clock
    input wire logic sys_clk,
    // command port
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic [15:0] cmd_wr_data,
    output logic cmd_rd,
    input wire logic [15:0] cmd_rd_data,
    input wire logic cmd_rd_valid
);
    // idle bus at time zero
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_wr_data = 16'h0000;
        cmd_rd = 1'b0;
    end
    // word write; callers keep the turn-off word below the turn-on word
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge sys_clk);
        cmd_code <= c;
        cmd_wr_data <= d;
        cmd_wr <= 1'b1;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
        cmd_wr_data <= ~d; // stale data never lingers
    endtask
    // word read, answer awaited for a few cycles only
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        @(posedge sys_clk);
        cmd_code <= c;
        cmd_rd <= 1'b1;
        @(posedge sys_clk);
        cmd_rd <= 1'b0;
        ok = 1'b0;
        d = 16'h0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge sys_clk);
            if (cmd_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = cmd_rd_data;
            end
        end
    endtask
endmodule // pvg_host

// [tb/pvg_chk_checker.sv]
// port assertions for the command register block
`timescale 1ns/1ps
module pvg_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // command port
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [15:0] cmd_rd_data,
    input wire logic cmd_rd_valid,
    input wire logic write_denied,
    input wire logic nvm_restore,
    input wire logic nvm_store,
    // analogue side and status
    input wire logic [7:0] power_input_voltage,
    input wire logic conv_enable_ok,
    input wire logic [5:0] turn_on_level,
    input wire logic [5:0] turn_off_level,
    input wire logic input_undervoltage_fault,
    input wire logic uv_mask_released,
    input wire logic off_low_input,
    input wire logic phase_write_locked
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // phase write arriving while the lock holds
    sequence s_locked_wr;
        cmd_wr && cmd_code == 8'h37 && phase_write_locked && !nvm_restore && !nvm_store;
    endsequence
    // enabled last cycle with input under the level the design used then
    sequence s_below_off;
        $past(conv_enable_ok) && $past(power_input_voltage) < {2'h0, turn_off_level};
    endsequence
    AST_RD_ANSWER: assert property (cmd_rd |=> cmd_rd_valid) else $error("read not answered");
    AST_RD_QUIET: assert property (!cmd_rd |=> !cmd_rd_valid) else $error("spurious read valid");
    AST_PHASE_TOP: assert property (cmd_rd && cmd_code == 8'h37 |=> cmd_rd_data[15:12] == 4'h0)
        else $error("phase top nibble not zero");
    AST_LOCK_DENY: assert property (s_locked_wr |=> write_denied) else $error("locked write not denied");
    AST_LOCK_HELD: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(phase_write_locked))
        else $error("lock changed after power-on");
    AST_MASK_HELD: assert property (uv_mask_released |=> uv_mask_released) else $error("mask rearmed");
    AST_FAULT_MASKED: assert property (!uv_mask_released |-> !input_undervoltage_fault)
        else $error("fault while masked");
    AST_MASK_CAUSE: assert property ($rose(uv_mask_released) |->
        $past(power_input_voltage) > {2'h0, turn_on_level}) else $error("mask released early");
    AST_OFF_LOW: assert property (s_below_off |-> off_low_input) else $error("low input not flagged");
endmodule // pvg_chk
bind pvg_cmd_regs pvg_chk u_chk (.sys_clk, .srst, .cmd_code, .cmd_wr, .cmd_rd, .cmd_rd_data, .cmd_rd_valid,
    .write_denied, .nvm_restore, .nvm_store, .power_input_voltage, .conv_enable_ok, .turn_on_level,
    .turn_off_level, .input_undervoltage_fault, .uv_mask_released, .off_low_input, .phase_write_locked);

// [tb/pvg_cmd_regs_test.sv]
// self-checking bench for the command register block
`timescale 1ns/1ps
module pvg_cmd_regs_test;
    logic sys_clk, srst, cmd_wr, cmd_rd, cmd_rd_valid, invalid_data, write_denied, nvm_restore, nvm_store;
    logic stack_multi, conv_enable_ok, clear_status, input_undervoltage_fault, uv_mask_released;
    logic off_low_input, phase_write_locked;
    logic [7:0] cmd_code, power_input_voltage;
    logic [15:0] cmd_wr_data, cmd_rd_data, nvm_vin_on, nvm_input_turn_off_threshold, nvm_phase, nvm_gain, iout_sensed;
    logic [15:0] oc_fault_limit_raw, oc_warn_limit_raw, iout_reported, oc_fault_limit_eff, oc_warn_limit_eff;
    logic [5:0] turn_on_level, turn_off_level;
    logic [8:0] phase_delay_deg;
    logic [15:0] rv [5] = '{16'hF028, 16'hF024, 16'h0010, 16'hC880, 16'h0000};
    int num_errors = 0;
    int n_tests = 0;
    pvg_cmd_regs dut (.sys_clk, .srst, .cmd_code, .cmd_wr, .cmd_wr_data, .cmd_rd, .cmd_rd_data, .cmd_rd_valid,
        .invalid_data, .write_denied, .nvm_restore, .nvm_store, .nvm_vin_on, .nvm_input_turn_off_threshold, .nvm_phase,
        .nvm_gain, .stack_multi, .power_input_voltage, .conv_enable_ok, .clear_status, .iout_sensed,
        .oc_fault_limit_raw, .oc_warn_limit_raw, .turn_on_level, .turn_off_level, .phase_delay_deg,
        .iout_reported, .oc_fault_limit_eff, .oc_warn_limit_eff, .input_undervoltage_fault,
        .uv_mask_released, .off_low_input, .phase_write_locked);
    pvg_host host (.sys_clk, .cmd_code, .cmd_wr, .cmd_wr_data, .cmd_rd, .cmd_rd_data, .cmd_rd_valid);
    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.rd(c, d, ok);
        if (!ok) begin
            num_errors++;
            end_sim;
        end else begin
            chk(d, exp);
        end
    endtask
    // let level and gain outputs land
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // refused write: flag pulse, old word kept
    task automatic wr_bad(input logic [7:0] c, input logic [15:0] d, input logic [15:0] keep);
        host.wr(c, d);
        #1;
        chk(16'(invalid_data), 16'h0001);
        rc(c, keep);
    endtask
    // one-cycle pulse on restore, store or clear
    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk);
        {nvm_restore, nvm_store, clear_status} <= m;
        @(posedge sys_clk);
        {nvm_restore, nvm_store, clear_status} <= 3'h0;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    // main sequence
    initial begin
        srst = 1'b1;
        {nvm_restore, nvm_store, stack_multi, conv_enable_ok, clear_status} = 5'h00;
        {nvm_vin_on, nvm_input_turn_off_threshold, nvm_phase, nvm_gain} = {16'hF03F, 16'hE84B, 16'h0532, 16'h1001};
        power_input_voltage = 8'h20;
        iout_sensed = 16'h0200;
        oc_fault_limit_raw = 16'h0400;
        oc_warn_limit_raw = 16'h0200;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) rc(8'(8'h35 + i), rv[i]);
        chk(16'(turn_off_level), 16'h0024);
        chk(iout_reported, 16'h0200);
        done("reset");
        host.wr(8'h35, 16'hF03F);
        host.wr(8'h36, 16'hE84B);
        settle;
        chk(16'(turn_on_level), 16'h003F);
        chk(16'(turn_off_level), 16'h0025);
        rc(8'h36, 16'hE84B);
        wr_bad(8'h36, 16'hF008, 16'hE84B);
        wr_bad(8'h35, 16'hF040, 16'hF03F);
        wr_bad(8'h37, 16'h0022, 16'h0010);
        wr_bad(8'h38, 16'hC900, 16'hC880);
        done("thresholds");
        @(posedge sys_clk);
        conv_enable_ok <= 1'b1;
        settle;
        chk(16'({off_low_input, input_undervoltage_fault}), 16'h0002);
        @(posedge sys_clk);
        power_input_voltage <= 8'h41;
        settle;
        chk(16'(uv_mask_released), 16'h0001);
        @(posedge sys_clk);
        power_input_voltage <= 8'h20;
        settle;
        chk(16'(input_undervoltage_fault), 16'h0001);
        @(posedge sys_clk);
        power_input_voltage <= 8'h30;
        pulse(3'h1);
        settle;
        chk(16'(off_low_input), 16'h0000);
        done("undervoltage");
        for (int n = 1; n <= 4; n++) begin
            for (int p = 0; p < n; p++) begin
                host.wr(8'h37, 16'(16'h0300 + n * 16 + p));
                settle;
                chk(16'(phase_delay_deg), 16'(360 / n * p));
            end
        end
        rc(8'h37, 16'h0343);
        done("phase");
        host.wr(8'h38, 16'hBB01);
        settle;
        chk(iout_reported, 16'h0301);
        chk(oc_fault_limit_eff, 16'h0602);
        chk(oc_warn_limit_eff, 16'h0301);
        pulse(3'h2);
        settle;
        rc(8'h38, 16'hC8C0);
        chk(iout_reported, 16'h0300);
        pulse(3'h4);
        settle;
        rc(8'h36, 16'hF025);
        rc(8'h38, 16'hC8FE);
        chk(16'(phase_delay_deg), 16'h00F0);
        chk(16'(uv_mask_released), 16'h0001);
        done("gain and nvm");
        @(posedge sys_clk);
        {srst, stack_multi, power_input_voltage} <= {2'h3, 8'h20};
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        stack_multi <= 1'b0;
        host.wr(8'h37, 16'h0021);
        #1;
        chk(16'(write_denied), 16'h0001);
        chk(16'(phase_write_locked), 16'h0001);
        rc(8'h37, 16'h0010);
        chk(16'(uv_mask_released), 16'h0000);
        done("lock");
        end_sim;
    end
endmodule // pvg_cmd_regs_test
